/* logic/acc_channel.sv */
// per-channel control of the converter: muxes, interrupt flag, result formatting, scan, correction
`timescale 1ns/10ps
`include "acc_regs.svh"

// Notes on behaviour
// R01: negative select only drives the mux in differential source kinds.
// R02: low-half differential: 0-3 pins 0-3, 5 pad ground, 7 internal ground.
// R03: high-half differential: 0-3 pins 4-7, 7 pad ground.
// R04: condition 00 complete, 01 below threshold, 11 above; 10 reserved.
// R05: non-zero level enables request, raised while flag set.
// R06: flag sets on completion, or in compare mode only on condition met.
// R07: flag clears on vector acknowledge or software writing one.
// R08: 8-bit and right 12-bit: low byte bits 7:0; right 12-bit high nibble bits 11:8.
// R09: left 12-bit: high byte bits 11:4, low upper nibble bits 3:0.
// R10: right 12-bit high nibble sign-extends bit 11 when differential, else zero.
// R11: 8-bit high byte sign-extends bit 7 when signed, else zero.
// R12: reserved bits of control, flag and correction registers read zero.
// R13: scan active when count non-zero; positive mux is setting plus position.
// R14: position increments per conversion, wraps to zero after equalling count.
// R15: scan covers count plus one sources from setting plus position.
// R16: correction enable applies correction and adds thirteen cycles latency.
// R17: free-running with correction pays latency on first conversion only.
// R18: correction disabled delivers the raw result.
// R19: coefficients are ignored while correction is disabled.
// R20: software picks differential kinds only in signed conversion.
// R21: result registers update no later than the flag sets.
module acc_channel (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] source_kind,
    input wire logic signed_conversion_select,
    input wire logic free_running,
    input wire logic [1:0] result_format,
    input wire logic [15:0] compare_value,
    input wire logic conv_done,
    input wire logic [11:0] conv_value,
    input wire logic irq_ack,
    output logic [1:0] irq_req_level,
    output logic [3:0] pos_mux_sel,
    output logic [3:0] neg_mux_sel,
    output logic neg_pad_gnd,
    output logic neg_int_gnd,
    output logic neg_mux_valid,
    output logic result_ready
);
    // software-visible registers and the channel flag
    logic [3:0] positive_input_select_r;
    logic [2:0] negative_input_select_r;
    logic [1:0] irq_condition_r;
    logic [1:0] irq_priority_level_r;
    logic flag_r;
    logic [3:0] scan_position_r;
    logic [3:0] scan_count_r;
    logic correction_enable_r;
    logic [11:0] offset_coef_r;
    logic [11:0] gain_coef_r;

    // result bytes and the captured raw value
    logic [7:0] value_low_r;
    logic [7:0] value_high_r;
    logic [11:0] held_value_r;

    // correction latency sequencer
    logic [4:0] lat_cnt_r;
    logic first_done_r;
    acc_pkg::acc_state_t state_r;

    // value handed to the result bytes
    logic [11:0] corr_value;
    logic [11:0] final_value;

    // delivery strobe and compare outcome
    logic deliver;
    logic cond_met;

    // correction arithmetic
    logic signed [12:0] diff_s;
    logic [23:0] prod;
    logic [12:0] sum_u;

    // bus decode
    logic wr_hit_flags;

    // flip-flops behind the outputs
    logic [1:0] irq_req_level_r;
    logic [3:0] pos_mux_sel_r;
    logic [3:0] neg_mux_sel_r;
    logic neg_pad_gnd_r;
    logic neg_int_gnd_r;
    logic neg_mux_valid_r;
    logic result_ready_r;
    logic [7:0] reg_rdata_r;

    // source kind decode and positive mux sum
    logic differential;
    logic [4:0] pos_sum;

    // differential kinds decide right 12-bit sign extension and negative mux use
    assign differential = (source_kind == acc_pkg::ACC_SRC_DIFF_LOW) || (source_kind == acc_pkg::ACC_SRC_DIFF_HIGH);
    // software clears the flag by writing a one to bit 0
    assign wr_hit_flags = reg_wr && (reg_addr == `ACC_OFS_IRQ_FLAGS) && reg_wdata[0];
    // carry out of bit 3 is dropped on purpose: the mux index wraps modulo 16
    assign pos_sum = {1'b0, positive_input_select_r} + {1'b0, scan_position_r}; // R13

    // software-written configuration registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            positive_input_select_r <= 4'h0;
            negative_input_select_r <= 3'h0;
            irq_condition_r <= 2'h0;
            irq_priority_level_r <= 2'h0;
            scan_count_r <= 4'h0;
            correction_enable_r <= 1'b0;
            offset_coef_r <= 12'h000;
            gain_coef_r <= 12'h000;
        end else if (reg_wr) begin
            case (reg_addr)
                `ACC_OFS_MUX: begin
                    positive_input_select_r <= reg_wdata[6:3];
                    negative_input_select_r <= reg_wdata[2:0];
                end
                `ACC_OFS_IRQ_CTRL: begin
                    irq_condition_r <= reg_wdata[3:2];
                    irq_priority_level_r <= reg_wdata[1:0];
                end
                `ACC_OFS_SCAN: scan_count_r <= reg_wdata[3:0];
                `ACC_OFS_CORR: correction_enable_r <= reg_wdata[0];
                `ACC_OFS_OFFSET_LO: offset_coef_r[7:0] <= reg_wdata;
                `ACC_OFS_OFFSET_HI: offset_coef_r[11:8] <= reg_wdata[3:0];
                `ACC_OFS_GAIN_LO: gain_coef_r[7:0] <= reg_wdata;
                `ACC_OFS_GAIN_HI: gain_coef_r[11:8] <= reg_wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // offset and gain correction: (value - offset) * gain / 2048, saturated
    always_comb begin
        diff_s = $signed({1'b0, held_value_r}) - $signed({1'b0, offset_coef_r});
        prod = 24'h000000;
        sum_u = 13'h0000;
        if (diff_s < 0) begin
            corr_value = 12'h000;
        end else begin
            prod = 24'(diff_s[11:0]) * 24'(gain_coef_r);
            sum_u = prod[23:11];
            corr_value = (sum_u > 13'(`ACC_VALUE_MAX)) ? `ACC_VALUE_MAX : sum_u[11:0];
        end
        final_value = correction_enable_r ? corr_value : held_value_r; // R16 R18 R19
    end

    // correction latency sequencer; raw path delivers in the capture cycle's follower
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= acc_pkg::ACC_ST_IDLE;
            lat_cnt_r <= 5'h00;
            held_value_r <= 12'h000;
            first_done_r <= 1'b0;
        end else begin
            if (!free_running) begin
                first_done_r <= 1'b0;
            end
            case (state_r)
                acc_pkg::ACC_ST_IDLE: begin
                    if (conv_done) begin
                        held_value_r <= conv_value;
                        if (correction_enable_r && !(free_running && first_done_r)) begin
                            lat_cnt_r <= `ACC_CORR_LATENCY_CYC; // R16 R17
                            state_r <= acc_pkg::ACC_ST_WAIT;
                        end else begin
                            state_r <= acc_pkg::ACC_ST_DONE;
                        end
                    end
                end
                acc_pkg::ACC_ST_WAIT: begin
                    lat_cnt_r <= lat_cnt_r - 5'h01;
                    if (lat_cnt_r == 5'h01) begin
                        state_r <= acc_pkg::ACC_ST_DONE; // R16
                    end
                end
                acc_pkg::ACC_ST_DONE: begin
                    state_r <= acc_pkg::ACC_ST_IDLE;
                    if (free_running && correction_enable_r) begin
                        first_done_r <= 1'b1; // R17
                    end
                end
                default: state_r <= acc_pkg::ACC_ST_IDLE;
            endcase
        end
    end

    // one-cycle strobe towards flag, result bytes and ready pulse
    assign deliver = (state_r == acc_pkg::ACC_ST_DONE);

    // compare against threshold in the number format of the conversion
    always_comb begin
        case (irq_condition_r)
            acc_pkg::ACC_COND_COMPLETE: cond_met = 1'b1; // R04
            acc_pkg::ACC_COND_BELOW: begin
                if (signed_conversion_select) begin
                    cond_met = $signed({{4{final_value[11]}}, final_value}) < $signed(compare_value); // R04
                end else begin
                    cond_met = {4'h0, final_value} < compare_value;
                end
            end
            acc_pkg::ACC_COND_ABOVE: begin
                if (signed_conversion_select) begin
                    cond_met = $signed({{4{final_value[11]}}, final_value}) > $signed(compare_value); // R04
                end else begin
                    cond_met = {4'h0, final_value} > compare_value;
                end
            end
            default: cond_met = 1'b0; // reserved code never fires
        endcase
    end

    // channel interrupt flag: set wins over acknowledge and write-one clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_r <= 1'b0;
        end else if (deliver && cond_met) begin
            flag_r <= 1'b1; // R06
        end else if (irq_ack || wr_hit_flags) begin
            flag_r <= 1'b0; // R07
        end
    end

    // result byte formatting, written in the same edge the flag sets
    always_ff @(posedge clk) begin
        if (!nrst) begin
            value_low_r <= `ACC_RESET_BYTE;
            value_high_r <= `ACC_RESET_BYTE;
        end else if (deliver) begin // R21
            case (result_format)
                acc_pkg::ACC_FMT_12_LEFT: begin
                    value_high_r <= final_value[11:4]; // R09
                    value_low_r <= {final_value[3:0], 4'h0}; // R09
                end
                acc_pkg::ACC_FMT_8: begin
                    value_low_r <= final_value[7:0]; // R08
                    value_high_r <= signed_conversion_select ? {8{final_value[7]}} : 8'h00; // R11
                end
                default: begin
                    value_low_r <= final_value[7:0]; // R08
                    value_high_r <= {(differential ? {4{final_value[11]}} : 4'h0), final_value[11:8]}; // R08 R10
                end
            endcase
        end
    end

    // scan position advance and wrap
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scan_position_r <= 4'h0;
        end else if (reg_wr && reg_addr == `ACC_OFS_SCAN) begin
            scan_position_r <= reg_wdata[7:4];
        end else if (conv_done) begin
            if (scan_count_r == 4'h0) begin
                scan_position_r <= 4'h0;
            end else if (scan_position_r == scan_count_r) begin
                scan_position_r <= 4'h0; // R14
            end else begin
                scan_position_r <= scan_position_r + 4'h1; // R14 R15
            end
        end
    end

    // positive mux selection: setting plus scan position
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pos_mux_sel_r <= 4'h0;
        end else begin
            pos_mux_sel_r <= pos_sum[3:0]; // R13
        end
    end

    // negative mux selection towards the analog front end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            neg_mux_sel_r <= 4'h0;
            neg_pad_gnd_r <= 1'b0;
            neg_int_gnd_r <= 1'b0;
            neg_mux_valid_r <= 1'b0;
        end else begin
            neg_mux_sel_r <= 4'h0;
            neg_pad_gnd_r <= 1'b0;
            neg_int_gnd_r <= 1'b0;
            neg_mux_valid_r <= 1'b0;
            case (source_kind)
                acc_pkg::ACC_SRC_DIFF_LOW: begin
                    if (!negative_input_select_r[2]) begin
                        neg_mux_sel_r <= {2'h0, negative_input_select_r[1:0]}; // R02
                        neg_mux_valid_r <= 1'b1;
                    end else if (negative_input_select_r == `ACC_NEG_PAD_GND) begin
                        neg_pad_gnd_r <= 1'b1; // R02
                        neg_mux_valid_r <= 1'b1;
                    end else if (negative_input_select_r == `ACC_NEG_INT_GND) begin
                        neg_int_gnd_r <= 1'b1; // R02
                        neg_mux_valid_r <= 1'b1;
                    end
                end
                acc_pkg::ACC_SRC_DIFF_HIGH: begin
                    if (!negative_input_select_r[2]) begin
                        neg_mux_sel_r <= {2'h1, negative_input_select_r[1:0]}; // R03
                        neg_mux_valid_r <= 1'b1;
                    end else if (negative_input_select_r == `ACC_NEG_HI_PAD_GND) begin
                        neg_pad_gnd_r <= 1'b1; // R03
                        neg_mux_valid_r <= 1'b1;
                    end
                end
                default: begin
                end // R01
            endcase
        end
    end

    // interrupt request at the programmed level while the flag stands
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_req_level_r <= 2'h0;
        end else begin
            irq_req_level_r <= flag_r ? irq_priority_level_r : 2'h0; // R05
        end
    end

    // completion strobe, rises with the result bytes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_ready_r <= 1'b0;
        end else begin
            result_ready_r <= deliver;
        end
    end

    // read port, data one cycle after the strobe, reserved bits zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata_r <= `ACC_RESET_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACC_OFS_MUX: reg_rdata_r <= {1'b0, positive_input_select_r, negative_input_select_r};
                `ACC_OFS_IRQ_CTRL: reg_rdata_r <= {4'h0, irq_condition_r, irq_priority_level_r}; // R12
                `ACC_OFS_IRQ_FLAGS: reg_rdata_r <= {7'h00, flag_r}; // R12
                `ACC_OFS_VALUE_LOW: reg_rdata_r <= value_low_r;
                `ACC_OFS_VALUE_HIGH: reg_rdata_r <= value_high_r;
                `ACC_OFS_SCAN: reg_rdata_r <= {scan_position_r, scan_count_r};
                `ACC_OFS_CORR: reg_rdata_r <= {7'h00, correction_enable_r}; // R12
                `ACC_OFS_OFFSET_LO: reg_rdata_r <= offset_coef_r[7:0];
                `ACC_OFS_OFFSET_HI: reg_rdata_r <= {4'h0, offset_coef_r[11:8]};
                `ACC_OFS_GAIN_LO: reg_rdata_r <= gain_coef_r[7:0];
                `ACC_OFS_GAIN_HI: reg_rdata_r <= {4'h0, gain_coef_r[11:8]};
                default: reg_rdata_r <= `ACC_RESET_BYTE;
            endcase
        end else begin
            reg_rdata_r <= `ACC_RESET_BYTE;
        end
    end

    // outputs straight from their flip-flops
    assign reg_rdata = reg_rdata_r;
    assign irq_req_level = irq_req_level_r;
    assign pos_mux_sel = pos_mux_sel_r;
    assign neg_mux_sel = neg_mux_sel_r;
    assign neg_pad_gnd = neg_pad_gnd_r;
    assign neg_int_gnd = neg_int_gnd_r;
    assign neg_mux_valid = neg_mux_valid_r;
    assign result_ready = result_ready_r;
endmodule // acc_channel

/* shared/acc_regs.svh */
// register offsets, field positions, reset values and timing counts of the channel control block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_OFS_MUX 8'h01
`define ACC_OFS_IRQ_CTRL 8'h02
`define ACC_OFS_IRQ_FLAGS 8'h03
`define ACC_OFS_VALUE_LOW 8'h04
`define ACC_OFS_VALUE_HIGH 8'h05
`define ACC_OFS_SCAN 8'h06
`define ACC_OFS_CORR 8'h07
`define ACC_OFS_OFFSET_LO 8'h08
`define ACC_OFS_OFFSET_HI 8'h09
`define ACC_OFS_GAIN_LO 8'h0a
`define ACC_OFS_GAIN_HI 8'h0b
`define ACC_RESET_BYTE 8'h00
`define ACC_IRQ_CTRL_MASK 8'h0f
`define ACC_FLAG_MASK 8'h01
`define ACC_CORR_MASK 8'h01
`define ACC_MUX_MASK 8'h7f
`define ACC_NIB_MASK 8'h0f
`define ACC_CORR_LATENCY_CYC 5'h0d
`define ACC_GAIN_UNITY 12'h800
`define ACC_VALUE_MAX 12'hfff
`define ACC_NEG_PAD_GND 3'h5
`define ACC_NEG_INT_GND 3'h7
`define ACC_NEG_HI_PAD_GND 3'h7
`endif

/* shared/acc_pkg.sv */
// types of the channel control block
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_SRC_INTERNAL = 2'h0,
        ACC_SRC_SINGLE = 2'h1,
        ACC_SRC_DIFF_LOW = 2'h2,
        ACC_SRC_DIFF_HIGH = 2'h3
    } acc_source_kind_t;
    typedef enum logic [1:0] {
        ACC_COND_COMPLETE = 2'h0,
        ACC_COND_BELOW = 2'h1,
        ACC_COND_RESERVED = 2'h2,
        ACC_COND_ABOVE = 2'h3
    } acc_irq_condition_t;
    typedef enum logic [1:0] {
        ACC_FMT_12_RIGHT = 2'h0,
        ACC_FMT_8 = 2'h1,
        ACC_FMT_12_LEFT = 2'h2,
        ACC_FMT_RESERVED = 2'h3
    } acc_format_t;
    typedef enum logic [2:0] {
        ACC_ST_IDLE = 3'b001,
        ACC_ST_WAIT = 3'b010,
        ACC_ST_DONE = 3'b100
    } acc_state_t;
endpackage

/* tb/acc_channel_checker.sv */
// assertion checker of the channel control block, bound to its top module
`timescale 1ns/10ps
module acc_channel_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] source_kind,
    input wire logic conv_done,
    input wire logic irq_ack,
    input wire logic [1:0] irq_req_level,
    input wire logic [3:0] pos_mux_sel,
    input wire logic [3:0] neg_mux_sel,
    input wire logic neg_pad_gnd,
    input wire logic neg_int_gnd,
    input wire logic neg_mux_valid,
    input wire logic result_ready
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // acknowledge with no raw-path flag set racing it
    sequence ack_s;
        irq_ack && !$past(conv_done);
    endsequence
    // high-half kind followed by a pin selection
    sequence high_pin_s;
        (source_kind == 2'h3) ##1 (neg_mux_valid && !neg_pad_gnd);
    endsequence

    // negative select and grounds stay off outside differential kinds
    neg_unused_a: assert property (!source_kind[1] |=> !neg_mux_valid && !neg_pad_gnd && !neg_int_gnd)
        else $error("negative select active outside differential kinds");
    neg_ground_a: assert property ((neg_pad_gnd || neg_int_gnd) |-> neg_mux_valid && !(neg_pad_gnd && neg_int_gnd))
        else $error("ground selection inconsistent");
    neg_high_a: assert property (source_kind == 2'h3 |=> !neg_int_gnd)
        else $error("internal ground picked in high-half kind");
    neg_pin_a: assert property (high_pin_s |-> neg_mux_sel[3:2] == 2'h1)
        else $error("high-half pin outside 4 to 7");
    irq_clear_a: assert property (ack_s |-> ##2 irq_req_level == 2'h0)
        else $error("request still raised after acknowledge");
    ready_lat_a: assert property (result_ready |-> $past(conv_done, 2) || $past(conv_done, 15))
        else $error("result ready at a wrong distance from conversion");
    pos_hold_a: assert property (!$past(reg_wr, 2) && !$past(conv_done, 2) |-> $stable(pos_mux_sel))
        else $error("positive selection moved without cause");
    resv_ctrl_a: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved control bits not zero");
    resv_flag_a: assert property (reg_rd && (reg_addr == 8'h03 || reg_addr == 8'h07) |=> reg_rdata[7:1] == 7'h0)
        else $error("reserved flag or correction bits not zero");
endmodule // acc_channel_checker

bind acc_channel acc_channel_checker i_acc_channel_checker (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .source_kind(source_kind), .conv_done(conv_done), .irq_ack(irq_ack), .irq_req_level(irq_req_level),
    .pos_mux_sel(pos_mux_sel), .neg_mux_sel(neg_mux_sel), .neg_pad_gnd(neg_pad_gnd), .neg_int_gnd(neg_int_gnd),
    .neg_mux_valid(neg_mux_valid), .result_ready(result_ready)
);

/* tb/acc_channel_tb.sv */
// self-checking testbench of the channel control block
`timescale 1ns/10ps
module acc_channel_tb;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, conv_done = 1'b0, irq_ack = 1'b0;
    logic signed_conversion_select = 1'b0, free_running = 1'b0, rd_seen = 1'b0, fl;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] source_kind = 2'h0, result_format = 2'h0, irq_req_level;
    logic [15:0] compare_value = 16'h0000, e16;
    logic [11:0] conv_value = 12'h000, v;
    logic [3:0] pos_mux_sel, neg_mux_sel;
    logic neg_pad_gnd, neg_int_gnd, neg_mux_valid, result_ready;
    logic [7:0] exp_q[$];
    integer seed = 32'h458e;
    int err_total = 0, cmp_count = 0, i, k, c;

    acc_channel i_acc_channel (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .source_kind(source_kind),
        .signed_conversion_select(signed_conversion_select), .free_running(free_running),
        .result_format(result_format), .compare_value(compare_value), .conv_done(conv_done),
        .conv_value(conv_value), .irq_ack(irq_ack), .irq_req_level(irq_req_level), .pos_mux_sel(pos_mux_sel),
        .neg_mux_sel(neg_mux_sel), .neg_pad_gnd(neg_pad_gnd), .neg_int_gnd(neg_int_gnd),
        .neg_mux_valid(neg_mux_valid), .result_ready(result_ready));

    // clock of 10 ns
    always #5 clk = ~clk;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("errors %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read: the expected byte is noted, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) rd_seen <= reg_rd;
    always @(negedge clk) if (rd_seen) check("reg_rdata", 16'(reg_rdata), 16'(exp_q.pop_front()));

    // one conversion, result ready expected exactly lat cycles after the taken edge
    task automatic conv(input logic [11:0] cv, input int lat);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_value <= cv;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_value <= ~cv;
        repeat (lat) begin
            @(negedge clk);
            check("result_ready early", 16'(result_ready), 16'h0);
            @(posedge clk);
        end
        @(negedge clk);
        check("result_ready", 16'(result_ready), 16'h1);
    endtask

    task automatic neg_chk(input logic [1:0] sk, input logic [2:0] cd);
        logic [2:0] e;
        e = 3'b000;
        if (sk == 2'h2 && (cd < 3'h4 || cd == 3'h5)) e = {1'b1, cd == 3'h5, 1'b0};
        if (sk == 2'h2 && cd == 3'h7) e = 3'b101;
        if (sk == 2'h3 && cd < 3'h4) e = 3'b100;
        if (sk == 2'h3 && cd == 3'h7) e = 3'b110;
        check("neg_flags", 16'({neg_mux_valid, neg_pad_gnd, neg_int_gnd}), 16'(e));
        if (e == 3'b100) check("neg_mux_sel", 16'(neg_mux_sel), 16'({sk[0], cd[1:0]}));
    endtask

    function automatic logic [15:0] fmt_exp(input logic [11:0] x, input logic [1:0] f, input logic sg);
        if (f == 2'h2) return {x, 4'h0};
        if (f == 2'h1) return {{8{sg & x[7]}}, x[7:0]};
        return {{4{sg & x[11]}}, x};
    endfunction

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done;
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        // reset values, unmapped place, read-only and reserved bits
        for (i = 2; i < 8; i++) rd(8'(i), 8'h00);
        wr(8'h3c, 8'hff);
        rd(8'h3c, 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h00);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h0f);
        wr(8'h07, 8'hfe);
        rd(8'h07, 8'h00);
        // every negative code in every source kind
        for (k = 0; k < 4; k++) begin
            for (c = 0; c < 8; c++) begin
                @(posedge clk);
                source_kind <= 2'(k);
                signed_conversion_select <= k[1];
                wr(8'h01, 8'(c));
                repeat (2) @(negedge clk);
                neg_chk(2'(k), 3'(c));
            end
        end
        // result layouts, single-ended unsigned then differential signed
        wr(8'h02, 8'h01);
        for (i = 0; i < 6; i++) begin
            result_format <= 2'(i % 3);
            source_kind <= (i < 3) ? 2'h1 : 2'h2;
            signed_conversion_select <= (i >= 3);
            v = 12'($random(seed));
            conv(v, 1);
            e16 = fmt_exp(v, 2'(i % 3), i >= 3);
            rd(8'h04, e16[7:0]);
            rd(8'h05, e16[15:8]);
            rd(8'h03, 8'h01);
            @(negedge clk);
            check("irq_req_level", 16'(irq_req_level), 16'h1);
            wr(8'h03, 8'h01);
            rd(8'h03, 8'h00);
        end
        // every interrupt condition, unsigned against 0x800, then signed against zero, levels 0 to 2
        source_kind <= 2'h1;
        result_format <= 2'h0;
        for (i = 0; i < 8; i++) begin
            signed_conversion_select <= i[2];
            compare_value <= i[2] ? 16'h0000 : 16'h0800;
            wr(8'h02, {4'h0, 2'(i / 2), 2'(i % 3)});
            v = 12'($random(seed)) | 12'h001;
            v[11] = i[0];
            fl = (i < 3) || (i == 6);
            conv(v, 1);
            rd(8'h03, 8'(fl));
            @(negedge clk);
            check("irq_req_level", 16'(irq_req_level), 16'(fl ? 2'(i % 3) : 2'h0));
            @(posedge clk);
            irq_ack <= 1'b1;
            @(posedge clk);
            irq_ack <= 1'b0;
            rd(8'h03, 8'h00);
        end
        // scan from positive 3, position 1, count 2, then count 0
        wr(8'h01, 8'h18);
        rd(8'h01, 8'h18);
        wr(8'h06, 8'h12);
        for (i = 0; i < 7; i++) begin
            repeat (2) @(negedge clk);
            check("pos_mux_sel", 16'(pos_mux_sel), 16'(3 + (i + 1) % 3));
            conv(12'($random(seed)), 1);
        end
        rd(8'h06, 8'h22);
        wr(8'h06, 8'h00);
        conv(12'h123, 1);
        repeat (2) @(negedge clk);
        check("pos_mux_sel", 16'(pos_mux_sel), 16'h3);
        // correction: offset 0x010, gain half; off, on, free-running first and next
        wr(8'h08, 8'h10);
        wr(8'h0b, 8'h04);
        for (i = 0; i < 4; i++) begin
            if (i < 2) wr(8'h07, 8'(i));
            free_running <= (i > 1);
            v = 12'($random(seed)) | 12'h100;
            conv(v, (i == 1 || i == 2) ? 14 : 1);
            e16 = (i == 0) ? 16'(v) : 16'((v - 12'h010) >> 1);
            rd(8'h04, e16[7:0]);
            rd(8'h05, e16[15:8]);
        end
        test_done;
    end
endmodule // acc_channel_tb
